// *** core/serial_audio_port.sv ***
// Four serial input and four serial output audio ports with clock domain selection,
// channel mapping and word length conversion to and from the core's 8.24 words.
// Assumes an Avalon-MM master on clk_i and a free running link_clk_i for the pin side.
`timescale 1ns/100ps
`include "sap_map.svh"
module serial_audio_port import sap_pkg::*; #(
	parameter int BCLK_HALF = `SAP_BCLK_HALF
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic [15:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1535:0] in_ch_data_o,
	input wire logic [1535:0] out_ch_data_i,
	input wire logic [3:0] serial_data_input_i,
	output logic [3:0] serial_data_output_o,
	input wire logic [3:0] input_bit_clock_pin_i,
	output logic [3:0] input_bit_clock_pin_o,
	output logic [3:0] input_bit_clock_pin_oe_o,
	input wire logic [3:0] input_frame_clock_pin_i,
	output logic [3:0] input_frame_clock_pin_o,
	output logic [3:0] input_frame_clock_pin_oe_o,
	input wire logic [3:0] output_bit_clock_pin_i,
	output logic [3:0] output_bit_clock_pin_o,
	output logic [3:0] output_bit_clock_pin_oe_o,
	input wire logic [3:0] output_frame_clock_pin_i,
	output logic [3:0] output_frame_clock_pin_o,
	output logic [3:0] output_frame_clock_pin_oe_o
);

	function automatic logic [4:0] slots_of(input logic [2:0] m);
		case (slot_mode_e'(m))
			SM_2X32: slots_of = 5'd2;
			SM_4X32: slots_of = 5'd4;
			SM_8X32: slots_of = 5'd8;
			SM_16X32: slots_of = 5'd16;
			SM_4X16: slots_of = 5'd4;
			default: slots_of = 5'd2;
		endcase
	endfunction : slots_of

	function automatic word_t to_core(input word_t r, input logic [1:0] wl);
		case (word_len_e'(wl))
			WL_24: to_core = {{7{r[31]}}, r[31:8], 1'b0};
			WL_16: to_core = {{7{r[31]}}, r[31:16], 9'h000};
			default: to_core = r;
		endcase
	endfunction : to_core

	function automatic word_t to_serial(input word_t w, input logic [1:0] wl);
		logic [23:0] s;
		if (&w[31:24] || ~|w[31:24]) begin
			s = w[24:1];
		end else begin
			s = w[31] ? `SAP_SAT_NEG : `SAP_SAT_POS;
		end
		case (word_len_e'(wl))
			WL_24: to_serial = {s, 8'h00};
			WL_16: to_serial = {s[23:8], 16'h0000};
			default: to_serial = w;
		endcase
	endfunction : to_serial

	function automatic int ch_base(input int p);
		ch_base = (p < 2) ? p * 16 : 32 + (p - 2) * 8;
	endfunction : ch_base

	function automatic int ch_num(input int p);
		ch_num = (p < 2) ? 16 : 8;
	endfunction : ch_num

	// Register side, clk_i domain
	logic [15:0] cfg_ff [`SAP_NUM_ENG];
	logic [15:0] nxt_cfg [`SAP_NUM_ENG];
	logic cfg_tgl_ff, nxt_cfg_tgl;
	logic [7:0] stat_ff, nxt_stat;
	logic rd_done_ff, nxt_rd_done;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [7:0] ev_s1_ff, ev_s2_ff, ev_s3_ff;
	logic [7:0] ev;
	logic fmt_hit, stat_hit;
	logic [2:0] fmt_idx;

	// Pin side, link_clk_i domain
	logic lrst_s1_ff, lrst_n_ff;
	logic [19:0] pin_s1_ff, pin_s2_ff;
	logic cfg_s1_ff, cfg_s2_ff, cfg_s3_ff;
	logic [15:0] lcfg_ff [`SAP_NUM_ENG];
	logic [7:0] div_ff, nxt_div;
	logic bclk_gen_ff, nxt_bclk_gen;
	logic [511:0] cap_ff [4];
	logic [7:0] tgl_v;
	logic [7:0] fout_v;
	logic [7:0] master_v;
	logic [3:0] dout_v;
	word_t hold_ff [`SAP_NUM_CH];
	word_t in_ch_ff [`SAP_NUM_CH];
	logic [7:0] dom_b, dom_f;
	logic [3:0] sdi;

	assign fmt_hit = avs_address_i >= `SAP_FMT_BASE && avs_address_i <= `SAP_FMT_LAST && avs_address_i[1:0] == 2'b00;
	assign stat_hit = avs_address_i == `SAP_STATUS_ADDR;
	assign fmt_idx = avs_address_i[4:2];
	// Reads stall one cycle so read data comes from flops
	assign avs_waitrequest_o = avs_read_i & ~rd_done_ff;
	assign avs_readdata_o = rdata_ff;
	assign ev = ev_s3_ff ^ ev_s2_ff;

	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_cfg_tgl = cfg_tgl_ff;
		nxt_stat = stat_ff;
		nxt_rd_done = avs_read_i & ~rd_done_ff;
		nxt_rdata = rdata_ff;
		if (avs_write_i && fmt_hit) begin
			if (avs_byteenable_i[0]) begin
				nxt_cfg[fmt_idx][7:0] = avs_writedata_i[7:0];
			end
			if (avs_byteenable_i[1]) begin
				nxt_cfg[fmt_idx][15:8] = avs_writedata_i[15:8];
			end
			nxt_cfg_tgl = ~cfg_tgl_ff;
		end
		// Frame events win over a software clear in the same cycle
		if (avs_write_i && stat_hit && avs_byteenable_i[0]) begin
			nxt_stat = stat_ff & ~avs_writedata_i[7:0];
		end
		nxt_stat = nxt_stat | ev;
		if (avs_read_i && !rd_done_ff) begin
			if (fmt_hit) begin
				nxt_rdata = {16'h0000, cfg_ff[fmt_idx]};
			end else if (stat_hit) begin
				nxt_rdata = {24'h000000, stat_ff};
			end else begin
				nxt_rdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int j = 0; j < `SAP_NUM_ENG; j++) begin
				cfg_ff[j] <= `SAP_FMT_RESET;
			end
			cfg_tgl_ff <= 1'b0;
			stat_ff <= 8'h00;
			rd_done_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			ev_s1_ff <= 8'h00;
			ev_s2_ff <= 8'h00;
			ev_s3_ff <= 8'h00;
		end else begin
			cfg_ff <= nxt_cfg;
			cfg_tgl_ff <= nxt_cfg_tgl;
			stat_ff <= nxt_stat;
			rd_done_ff <= nxt_rd_done;
			rdata_ff <= nxt_rdata;
			ev_s1_ff <= tgl_v;
			ev_s2_ff <= ev_s1_ff;
			ev_s3_ff <= ev_s2_ff;
		end
	end

	// Per core channel: deliver received frames, capture words to send
	for (genvar c = 0; c < `SAP_NUM_CH; c++) begin : g_ch
		localparam int P = (c < 16) ? 0 : (c < 32) ? 1 : (c < 40) ? 2 : 3;
		localparam int K = c - ch_base(P);
		assign in_ch_data_o[c*32 +: 32] = in_ch_ff[c];
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				in_ch_ff[c] <= 32'h00000000;
				hold_ff[c] <= 32'h00000000;
			end else begin
				// Port P slot K to core channel c
				if (ev[P]) begin
					in_ch_ff[c] <= (5'(K) < slots_of(cfg_ff[P][2:0])) ?
						to_core(cap_ff[P][K*32 +: 32], cfg_ff[P][6:5]) : 32'h00000000;
				end
				// Core channel c to output port P
				if (ev[4+P]) begin
					// Channels past the slot count dropped
					hold_ff[c] <= (5'(K) < slots_of(cfg_ff[4+P][2:0])) ?
						to_serial(out_ch_data_i[c*32 +: 32], cfg_ff[4+P][6:5]) : 32'h00000000;
				end
			end
		end
	end

	// Link side: reset, pin synchronisers, config copy, bit clock divider
	assign dom_b = {pin_s2_ff[11:8], pin_s2_ff[3:0]};
	assign dom_f = {pin_s2_ff[15:12], pin_s2_ff[7:4]};
	assign sdi = pin_s2_ff[19:16];

	always_comb begin
		nxt_div = div_ff + 8'd1;
		nxt_bclk_gen = bclk_gen_ff;
		if (div_ff == 8'(BCLK_HALF - 1)) begin
			nxt_div = 8'd0;
			nxt_bclk_gen = ~bclk_gen_ff;
		end
	end

	always_ff @(posedge link_clk_i) begin
		lrst_s1_ff <= rst_n_i;
		lrst_n_ff <= lrst_s1_ff;
		pin_s1_ff <= {serial_data_input_i, output_frame_clock_pin_i, output_bit_clock_pin_i,
			input_frame_clock_pin_i, input_bit_clock_pin_i};
		pin_s2_ff <= pin_s1_ff;
		if (!lrst_n_ff) begin
			cfg_s1_ff <= 1'b0;
			cfg_s2_ff <= 1'b0;
			cfg_s3_ff <= 1'b0;
			div_ff <= 8'd0;
			bclk_gen_ff <= 1'b0;
			for (int j = 0; j < `SAP_NUM_ENG; j++) begin
				lcfg_ff[j] <= `SAP_FMT_RESET;
			end
		end else begin
			cfg_s1_ff <= cfg_tgl_ff;
			cfg_s2_ff <= cfg_s1_ff;
			cfg_s3_ff <= cfg_s2_ff;
			div_ff <= nxt_div;
			bclk_gen_ff <= nxt_bclk_gen;
			// Config is held steady in clk_i domain once the toggle is seen
			if (cfg_s3_ff != cfg_s2_ff) begin
				lcfg_ff <= cfg_ff;
			end
		end
	end

	// Eight engines, one per port: four input and four output
	for (genvar j = 0; j < `SAP_NUM_ENG; j++) begin : g_eng
		localparam bit IS_OUT = (j >= 4);
		localparam int P = j % 4;
		logic b_d_ff, f_d_ff, fout_ff, dout_ff, tgl_ff;
		logic nxt_b_d, nxt_f_d, nxt_fout, nxt_dout, nxt_tgl;
		logic [9:0] cnt_ff, nxt_cnt, len, idx, nidx;
		word_t sr_ff, nxt_sr;
		logic [511:0] buf_ff, nxt_buf, nxt_cap;
		logic master, slot16, b_lvl, f_lvl, rise, fall;
		logic [2:0] bsrc, fsrc;
		logic [3:0] slot;
		logic [4:0] bitn;

		assign bsrc = lcfg_ff[j][`SAP_BSRC_LSB +: 3];
		assign fsrc = lcfg_ff[j][`SAP_FSRC_LSB +: 3];
		assign master = bsrc == `SAP_SRC_MASTER && fsrc == `SAP_SRC_MASTER;
		assign slot16 = lcfg_ff[j][2:0] == SM_4X16 || lcfg_ff[j][2:0] == SM_2X16;
		assign len = {5'd0, slots_of(lcfg_ff[j][2:0])} << (slot16 ? 4 : 5);
		// Any domain of the own direction
		assign b_lvl = master ? bclk_gen_ff : dom_b[{IS_OUT, bsrc[1:0]}];
		assign f_lvl = dom_f[{IS_OUT, fsrc[1:0]}];
		assign rise = b_lvl & ~b_d_ff;
		assign fall = ~b_lvl & b_d_ff;
		assign tgl_v[j] = tgl_ff;
		assign fout_v[j] = fout_ff;
		assign master_v[j] = master;

		always_comb begin
			nxt_b_d = b_lvl;
			nxt_f_d = f_d_ff;
			nxt_cnt = cnt_ff;
			nxt_fout = fout_ff;
			nxt_dout = dout_ff;
			nxt_tgl = tgl_ff;
			nxt_sr = sr_ff;
			nxt_buf = buf_ff;
			nxt_cap = 512'h0;
			// Slave realigns on a frame clock rise; master and a lost frame clock wrap
			idx = (cnt_ff >= len) ? 10'd0 : cnt_ff;
			if (rise) begin
				nxt_f_d = f_lvl;
				if (!master && f_lvl && !f_d_ff) begin
					idx = 10'd0;
				end
			end
			slot = slot16 ? idx[7:4] : idx[8:5];
			bitn = slot16 ? {1'b0, idx[3:0]} : idx[4:0];
			nidx = (idx + 10'd1 >= len) ? 10'd0 : idx + 10'd1;
			if (rise) begin
				nxt_cnt = idx + 10'd1;
				nxt_fout = nidx < (len >> 1);
				if (!IS_OUT) begin
					nxt_sr = {sr_ff[30:0], sdi[P]};
					if (bitn == (slot16 ? 5'd15 : 5'd31)) begin
						nxt_buf[slot*32 +: 32] = slot16 ? {sr_ff[14:0], sdi[P], 16'h0000} : {sr_ff[30:0], sdi[P]};
					end
					if (idx == 10'd0) begin
						nxt_cap = buf_ff;
						nxt_tgl = ~tgl_ff;
					end
				end
			end
			if (fall && IS_OUT) begin
				if (idx == 10'd0) begin
					for (int k = 0; k < `SAP_SLOT_MAX; k++) begin
						nxt_buf[k*32 +: 32] = (k < ch_num(P)) ? hold_ff[6'(ch_base(P) + k)] : 32'h00000000;
					end
					nxt_tgl = ~tgl_ff;
					nxt_dout = hold_ff[6'(ch_base(P))][31];
				end else begin
					nxt_dout = buf_ff[{slot, ~bitn}];
				end
			end
		end

		always_ff @(posedge link_clk_i) begin
			if (!lrst_n_ff) begin
				b_d_ff <= 1'b0;
				f_d_ff <= 1'b0;
				fout_ff <= 1'b0;
				dout_ff <= 1'b0;
				tgl_ff <= 1'b0;
				cnt_ff <= 10'd0;
				sr_ff <= 32'h00000000;
				buf_ff <= 512'h0;
			end else begin
				b_d_ff <= nxt_b_d;
				f_d_ff <= nxt_f_d;
				fout_ff <= nxt_fout;
				dout_ff <= nxt_dout;
				tgl_ff <= nxt_tgl;
				cnt_ff <= nxt_cnt;
				sr_ff <= nxt_sr;
				buf_ff <= nxt_buf;
			end
		end

		if (IS_OUT) begin : g_out
			assign dout_v[P] = dout_ff;
		end else begin : g_in
			// Frame stays put a whole frame while clk_i copies it
			always_ff @(posedge link_clk_i) begin
				if (!lrst_n_ff) begin
					cap_ff[P] <= 512'h0;
				end else if (rise && idx == 10'd0) begin
					cap_ff[P] <= nxt_cap;
				end
			end
		end
	end

	// Master drives its own domain pins
	assign input_bit_clock_pin_o = {4{bclk_gen_ff}};
	assign input_bit_clock_pin_oe_o = master_v[3:0];
	assign input_frame_clock_pin_o = fout_v[3:0];
	assign input_frame_clock_pin_oe_o = master_v[3:0];
	assign output_bit_clock_pin_o = {4{bclk_gen_ff}};
	assign output_bit_clock_pin_oe_o = master_v[7:4];
	assign output_frame_clock_pin_o = fout_v[7:4];
	assign output_frame_clock_pin_oe_o = master_v[7:4];
	assign serial_data_output_o = dout_v;
	// Flexible word length passes as 32-bit here
endmodule : serial_audio_port

// *** core/sap_map.svh ***
// Register offsets, field positions, reset values and counts of the serial audio ports.
// Assumes inclusion by bare name from the design files.
`ifndef SAP_MAP_SVH
`define SAP_MAP_SVH
`define SAP_FMT_BASE 16'hf200
`define SAP_FMT_LAST 16'hf21c
`define SAP_STATUS_ADDR 16'hf240
`define SAP_FMT_RESET 16'h0000
`define SAP_FSRC_LSB 13
`define SAP_BSRC_LSB 10
`define SAP_WLEN_LSB 5
`define SAP_MODE_LSB 0
`define SAP_SRC_MASTER 3'b100
`define SAP_NUM_ENG 8
`define SAP_NUM_CH 48
`define SAP_SLOT_MAX 16
`define SAP_SAT_POS 24'h7fffff
`define SAP_SAT_NEG 24'h800000
`define SAP_BCLK_HALF 2
`endif

// *** core/sap_pkg.sv ***
// Types shared by the serial audio port design.
// Assumes sap_map.svh supplies the numeric constants.
package sap_pkg;
	typedef logic [31:0] word_t;
	typedef enum logic [1:0] {
		WL_24 = 2'b00,
		WL_16 = 2'b01,
		WL_32 = 2'b10,
		WL_FLEX = 2'b11
	} word_len_e;
	typedef enum logic [2:0] {
		SM_2X32 = 3'b000,
		SM_4X32 = 3'b001,
		SM_8X32 = 3'b010,
		SM_16X32 = 3'b011,
		SM_4X16 = 3'b100,
		SM_2X16 = 3'b101
	} slot_mode_e;
endpackage : sap_pkg

// *** verif/sap_properties.sv ***
// Bus and clock pin checks on the serial audio port top.
// Assumes bind to serial_audio_port, all sampled on clk_i.
`timescale 1ns/100ps
module sap_properties #(
	parameter int BCLK_HALF = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [3:0] input_bit_clock_pin_oe_o,
	input wire logic [3:0] input_frame_clock_pin_oe_o,
	input wire logic [3:0] output_bit_clock_pin_o,
	input wire logic [3:0] output_bit_clock_pin_oe_o,
	input wire logic [3:0] output_frame_clock_pin_oe_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic fmt_hit;
	logic ans;
	assign fmt_hit = avs_address_i[15:5] == 11'h790 && avs_address_i[1:0] == 2'h0;
	assign ans = avs_read_i && !avs_waitrequest_o;
	sequence read_wait_s;
		avs_waitrequest_o ##1 !avs_waitrequest_o;
	endsequence
	a_write_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o)
		else $error("write stalled");
	a_read_one_wait: assert property ($rose(avs_read_i) |-> read_wait_s)
		else $error("read answer timing wrong");
	a_read_data_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data moved without a read");
	a_fmt_upper_zero: assert property (ans && fmt_hit |-> avs_readdata_o[31:16] == 16'h0000)
		else $error("format read upper half not zero");
	a_unmapped_zero: assert property (ans && !fmt_hit && avs_address_i != 16'hf240 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_out_pins_pair: assert property (output_bit_clock_pin_oe_o == output_frame_clock_pin_oe_o)
		else $error("output domain drives one clock pin only");
	a_in_pins_pair: assert property (input_bit_clock_pin_oe_o == input_frame_clock_pin_oe_o)
		else $error("input domain drives one clock pin only");
	// Master bit clock aliases against clk_i, so allow a wide window
	a_master_bit_clock: assert property (output_bit_clock_pin_oe_o[3] |-> ##[1:40] $changed(output_bit_clock_pin_o[3]))
		else $error("master bit clock stuck");
endmodule : sap_properties
bind serial_audio_port sap_properties #(.BCLK_HALF(BCLK_HALF)) u_sap_properties (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o),
	.input_bit_clock_pin_oe_o(input_bit_clock_pin_oe_o),
	.input_frame_clock_pin_oe_o(input_frame_clock_pin_oe_o),
	.output_bit_clock_pin_o(output_bit_clock_pin_o),
	.output_bit_clock_pin_oe_o(output_bit_clock_pin_oe_o),
	.output_frame_clock_pin_oe_o(output_frame_clock_pin_oe_o)
);

// *** verif/audio_far_end.sv ***
// Far-side converter: bit and frame clock, two 32-bit slots out, slot 0 captured.
// Assumes the device is clock slave on every domain these clocks reach.
`timescale 1ns/100ps
module audio_far_end (
	input wire logic link_clk_i,
	input wire logic [31:0] tx0_i,
	input wire logic [31:0] tx1_i,
	input wire logic sdout_i,
	output logic bclk_o,
	output logic fclk_o,
	output logic sdata_o,
	output logic [31:0] rx0_o
);
	// Slow enough that the device's synchronised output settles before our rise
	logic [2:0] div_ff = 3'h0;
	logic [5:0] bit_ff = 6'h3f;
	logic [5:0] nx;
	logic [62:0] sh_ff;
	wire [63:0] fr = {tx0_i, tx1_i};
	initial begin
		fclk_o = 1'h0;
		sdata_o = 1'h0;
		rx0_o = 32'h0;
	end
	always @(posedge link_clk_i) div_ff <= div_ff + 3'h1;
	assign bclk_o = div_ff[2];
	assign nx = bit_ff + 6'h1;
	// frame high first half, MSB first
	always @(negedge bclk_o) begin
		bit_ff <= nx;
		fclk_o <= ~nx[5];
		sdata_o <= fr[~nx];
	end
	// slot 0 is the first 32 bits
	always @(posedge bclk_o) begin
		sh_ff <= {sh_ff[61:0], sdout_i};
		if (bit_ff == 6'h3f) rx0_o <= sh_ff[62:31];
	end
endmodule : audio_far_end

// *** verif/tb_top.sv ***
// Bench for the serial audio ports: register access, input and output conversion.
// Assumes the far-side model clocks every domain the device does not drive.
`timescale 1ns/100ps
`include "sap_map.svh"
module tb_top import sap_pkg::*;;
	logic clk_i = 1'h0;
	logic lclk = 1'h0;
	logic rst_n_i = 1'h0;
	logic [15:0] adr = 16'h0;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata, rdo, rx0, h;
	logic [31:0] tx0 = 32'h8123_4567;
	logic [31:0] tx1 = 32'h0abc_def1;
	logic [1535:0] in_ch;
	logic [1535:0] out_ch = '0;
	logic [3:0] ib_o, ib_oe, if_o, if_oe, ob_o, ob_oe, of_o, of_oe, sdo;
	logic bclk, fclk, sdi, wq;
	logic [1:0] owl [4] = '{WL_32, WL_24, WL_24, WL_16};
	logic [31:0] oin [4] = '{32'h1357_9bdf, 32'h0200_0000, 32'hf000_0000, 32'h0012_3456};
	logic [31:0] oexp [4] = '{32'h1357_9bdf, 32'h7fff_ff00, 32'h8000_0000, 32'h091a_0000};
	int mismatches = 0;
	int checks_done = 0;
	wire [63:0] fr = {tx0, tx1};
	// Shared pins resolve to whoever enables them
	wire [3:0] ib_w = ib_oe & ib_o | ~ib_oe & {4{bclk}};
	wire [3:0] if_w = if_oe & if_o | ~if_oe & {4{fclk}};
	wire [3:0] ob_w = ob_oe & ob_o | ~ob_oe & {4{bclk}};
	wire [3:0] of_w = of_oe & of_o | ~of_oe & {4{fclk}};
	always #50 clk_i = ~clk_i;
	initial begin
		#2.5;
		forever #6 lclk = ~lclk;
	end
	serial_audio_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(lclk), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdo), .avs_waitrequest_o(wq), .in_ch_data_o(in_ch), .out_ch_data_i(out_ch),
		.serial_data_input_i({4{sdi}}), .serial_data_output_o(sdo),
		.input_bit_clock_pin_i(ib_w), .input_bit_clock_pin_o(ib_o), .input_bit_clock_pin_oe_o(ib_oe),
		.input_frame_clock_pin_i(if_w), .input_frame_clock_pin_o(if_o), .input_frame_clock_pin_oe_o(if_oe),
		.output_bit_clock_pin_i(ob_w), .output_bit_clock_pin_o(ob_o), .output_bit_clock_pin_oe_o(ob_oe),
		.output_frame_clock_pin_i(of_w), .output_frame_clock_pin_o(of_o), .output_frame_clock_pin_oe_o(of_oe));
	audio_far_end far (.link_clk_i(lclk), .tx0_i(tx0), .tx1_i(tx1), .sdout_i(sdo[0]), .bclk_o(bclk),
		.fclk_o(fclk), .sdata_o(sdi), .rx0_o(rx0));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		do @(posedge clk_i); while (wq !== 1'h0);
		q = rdo;
		wr <= 1'h0;
		rd <= 1'h0;
	endtask : bus
	task automatic frames(input int k, input int n);
		repeat (n) begin
			bus(1'h1, `SAP_STATUS_ADDR, 32'h0000_00ff, rdata);
			do bus(1'h0, `SAP_STATUS_ADDR, 32'h0, rdata); while (rdata[k] !== 1'h1);
		end
	endtask : frames
	function automatic logic [31:0] fmt(input logic [2:0] src, input logic [1:0] wl, input logic [2:0] sm);
		return {16'h0, src, src, 3'h0, wl, 2'h0, sm};
	endfunction : fmt
	function automatic logic [31:0] ch(input int c);
		return in_ch[c*32 +: 32];
	endfunction : ch
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		#3000000;
		mismatches++;
		wrap_up();
	end
	initial begin
		int b;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'h1;
		bus(1'h0, `SAP_FMT_BASE, 32'h0, rdata);
		chk("fmt reset", rdata, {16'h0, `SAP_FMT_RESET});
		bus(1'h0, 16'hf220, 32'h0, rdata);
		chk("unmapped", rdata, 32'h0);
		// Each input port on a different slave domain
		for (int k = 0; k < 4; k++)
			bus(1'h1, `SAP_FMT_BASE + 16'(4 * k), 32'hffff_0000 | fmt(3'(k), WL_32, SM_2X32), rdata);
		bus(1'h0, `SAP_FMT_BASE + 16'hc, 32'h0, rdata);
		chk("fmt back", rdata, fmt(3'h3, WL_32, SM_2X32));
		frames(3, 3);
		for (int k = 0; k < 4; k++) begin
			b = (k < 2) ? 16 * k : 16 + 8 * k;
			chk("in slot0", ch(b), tx0);
			chk("in slot1", ch(b + 1), tx1);
			chk("in unused", ch(b + 2), 32'h0);
		end
		bus(1'h1, `SAP_FMT_BASE, fmt(3'h0, WL_24, SM_2X32), rdata);
		frames(0, 3);
		chk("in 24 neg", ch(0), {{7{tx0[31]}}, tx0[31:8], 1'h0});
		chk("in 24 pos", ch(1), {{7{tx1[31]}}, tx1[31:8], 1'h0});
		bus(1'h1, `SAP_FMT_BASE, fmt(3'h0, WL_16, SM_4X16), rdata);
		frames(0, 3);
		for (int s = 0; s < 5; s++) begin
			h = (s < 4) ? {16'h0, fr[63 - 16 * s -: 16]} : 32'h0;
			chk("in 16", ch(s), {{7{h[15]}}, h[15:0], 9'h0});
		end
		// Output port 0 as slave on domain 0
		for (int i = 0; i < 4; i++) begin
			out_ch[31:0] <= oin[i];
			bus(1'h1, `SAP_FMT_BASE + 16'h10, fmt(3'h0, owl[i], SM_2X32), rdata);
			frames(4, 5);
			chk("out slot0", rx0, oexp[i]);
		end
		bus(1'h1, `SAP_FMT_LAST, fmt(`SAP_SRC_MASTER, WL_32, SM_2X32), rdata);
		frames(7, 2);
		chk("master oe", {16'h0, ob_oe, of_oe, ib_oe, if_oe}, 32'h0000_8800);
		wrap_up();
	end
endmodule : tb_top
